// ### apmc_defs.vh
// constants of the accelerometer power-mode controller
`ifndef APMC_DEFS_VH
`define APMC_DEFS_VH
`define APMC_ADDR_INACT_THRESH 8'h25
`define APMC_ADDR_INACT_TIME 8'h26
`define APMC_ADDR_RATE_SEL 8'h2C
`define APMC_ADDR_PWR_CTL 8'h2D
`define APMC_RATE_RESET 8'h0A
`define APMC_PWR_RESET 8'h00
`define APMC_BIT_MEASURE 3
`define APMC_BIT_LINK 5
`define APMC_BIT_SLEEP_EN 4
`define APMC_BIT_LOW_POWER 4
`define APMC_CODE_MIN 4'h6
`define APMC_CODE_LP_LO 4'h7
`define APMC_CODE_LP_HI 4'hC
`define APMC_CODE_SLEEP 4'h6
`define APMC_CLK_HZ 250000000
`define APMC_TURNON_US 1100
`define APMC_TURNON_CYC ((`APMC_CLK_HZ / 1000000) * `APMC_TURNON_US)
`define APMC_BASE_HZ_X100 625
`endif

// ### apmc_rate_tick.v
// sample-tick divider from a four-bit rate code
`timescale 1ns/10ps
`include "apmc_defs.vh"
module apmc_rate_tick #(
   parameter CLK_HZ = `APMC_CLK_HZ
)(
   clk,
   sys_rst,
   run,
   rateCode,
   tick
);
   input wire clk;
   input wire sys_rst;
   input wire run;
   input wire [3:0] rateCode;
   output reg tick;
   // slowest period in cycles: clk/6.25Hz, computed as (clk/625)*100
   localparam [31:0] SLOW_CYC = (CLK_HZ / `APMC_BASE_HZ_X100) * 100;
   reg [31:0] cnt_r;
   wire [3:0] step;
   wire [31:0] period;
   assign step = rateCode - `APMC_CODE_MIN;
   assign period = SLOW_CYC >> step;
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt_r <= 32'h0;
         tick <= 1'b0;
      end
      else if (!run)
      begin
         // idle path: counter frozen at zero, no ticks
         cnt_r <= 32'h0;
         tick <= 1'b0;
      end
      else if (cnt_r >= period - 32'h1)
      begin
         cnt_r <= 32'h0;
         tick <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule // apmc_rate_tick

// ### apmc_power_ctrl.v
// power-mode controller: registers, standby/measure/sleep, sample timing
`timescale 1ns/10ps
`include "apmc_defs.vh"
module apmc_power_ctrl #(
   parameter TURNON_CYC = `APMC_TURNON_CYC
)(
   clk,
   sys_rst,
   regWrite,
   regRead,
   regAddr,
   regWdata,
   regRdata,
   inactive,
   i2cMode,
   spi3Wire,
   serialOutBit,
   serialOutEn,
   dataPinOut,
   dataPinOutEn,
   dataPinIn,
   addrSelPinIn,
   dataPinRx,
   altAddrSel,
   measuring,
   sleeping,
   lowPowerActive,
   sampleTick,
   dataValid,
   fifoHold,
   inactThreshold,
   inactTime
);
   input wire clk;
   input wire sys_rst;
   input wire regWrite;
   input wire regRead;
   input wire [7:0] regAddr;
   input wire [7:0] regWdata;
   output reg [7:0] regRdata;
   input wire inactive;
   input wire i2cMode;
   input wire spi3Wire;
   input wire serialOutBit;
   input wire serialOutEn;
   output wire dataPinOut;
   output wire dataPinOutEn;
   input wire dataPinIn;
   input wire addrSelPinIn;
   output wire dataPinRx;
   output reg altAddrSel;
   output reg measuring;
   output reg sleeping;
   output reg lowPowerActive;
   output wire sampleTick;
   output reg dataValid;
   output wire fifoHold;
   output wire [7:0] inactThreshold;
   output wire [7:0] inactTime;

   localparam ST_STANDBY = 2'd0;
   localparam ST_WARMUP = 2'd1;
   localparam ST_MEASURE = 2'd2;
   localparam ST_SLEEP = 2'd3;

   reg [7:0] thresh_r;
   reg [7:0] time_r;
   reg [7:0] rate_r;
   reg [7:0] pwr_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [31:0] warm_r;
   reg sawTick_r;
   reg [1:0] pinSync_r;
   reg [1:0] addrSync_r;
   reg [1:0] inactSync_r;
   wire measureBit;
   wire autoSleep;
   wire [3:0] activeCode;
   wire running;

   function [3:0] legal_code;
      input [3:0] code;
      begin
         // reserved codes below 0110 fall to the slowest defined rate
         if (code < `APMC_CODE_MIN)
            legal_code = `APMC_CODE_MIN;
         else
            legal_code = code;
      end
   endfunction

   assign inactThreshold = thresh_r;
   assign inactTime = time_r;
   assign measureBit = pwr_r[`APMC_BIT_MEASURE];
   assign autoSleep = pwr_r[`APMC_BIT_SLEEP_EN] & pwr_r[`APMC_BIT_LINK];

   // registers writable in every state, standby included
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         thresh_r <= 8'h00;
         time_r <= 8'h00;
         rate_r <= `APMC_RATE_RESET;
         pwr_r <= `APMC_PWR_RESET;
      end
      else if (regWrite)
      begin
         case (regAddr)
            `APMC_ADDR_INACT_THRESH: thresh_r <= regWdata;
            `APMC_ADDR_INACT_TIME: time_r <= regWdata;
            `APMC_ADDR_RATE_SEL: rate_r <= regWdata;
            `APMC_ADDR_PWR_CTL: pwr_r <= regWdata;
            default: thresh_r <= thresh_r;
         endcase
      end
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         regRdata <= 8'h00;
      else if (regRead)
      begin
         case (regAddr)
            `APMC_ADDR_INACT_THRESH: regRdata <= thresh_r;
            `APMC_ADDR_INACT_TIME: regRdata <= time_r;
            `APMC_ADDR_RATE_SEL: regRdata <= rate_r;
            `APMC_ADDR_PWR_CTL: regRdata <= pwr_r;
            default: regRdata <= 8'h00;
         endcase
      end
   end

   // pins and the inactivity flag come from outside the clock domain
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pinSync_r <= 2'b00;
         addrSync_r <= 2'b00;
         inactSync_r <= 2'b00;
      end
      else
      begin
         pinSync_r <= {pinSync_r[0], dataPinIn};
         addrSync_r <= {addrSync_r[0], addrSelPinIn};
         inactSync_r <= {inactSync_r[0], inactive};
      end
   end

   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_STANDBY:
            if (measureBit)
               state_nxt = ST_WARMUP;
         ST_WARMUP:
            if (!measureBit)
               state_nxt = ST_STANDBY;
            else if (warm_r == 32'h0 && sawTick_r)
               state_nxt = ST_MEASURE;
         ST_MEASURE:
            if (!measureBit)
               state_nxt = ST_STANDBY;
            else if (autoSleep && inactSync_r[1])
               state_nxt = ST_SLEEP;
         ST_SLEEP:
            if (!measureBit)
               state_nxt = ST_STANDBY;
            else if (!autoSleep || !inactSync_r[1])
               state_nxt = ST_WARMUP;
         default:
            state_nxt = ST_STANDBY;
      endcase
   end

   assign running = (state_r != ST_STANDBY);
   assign activeCode = (state_r == ST_SLEEP) ? `APMC_CODE_SLEEP
      : legal_code(rate_r[3:0]);

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r <= ST_STANDBY;
         warm_r <= 32'h0;
         sawTick_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_r != ST_WARMUP && state_nxt == ST_WARMUP)
         begin
            warm_r <= TURNON_CYC;
            sawTick_r <= 1'b0;
         end
         else if (state_r == ST_WARMUP)
         begin
            // countdown waits for the first sample, so the delay adds to one period
            if (warm_r != 32'h0 && sawTick_r)
               warm_r <= warm_r - 32'h1;
            if (sampleTick)
               sawTick_r <= 1'b1; // one sample period elapsed
         end
      end
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         measuring <= 1'b0;
         sleeping <= 1'b0;
         dataValid <= 1'b0;
         lowPowerActive <= 1'b0;
         altAddrSel <= 1'b0;
      end
      else
      begin
         measuring <= (state_r != ST_STANDBY);
         sleeping <= (state_r == ST_SLEEP);
         dataValid <= (state_r == ST_MEASURE) || (state_r == ST_SLEEP);
         // saving only inside 12.5..400 Hz; elsewhere the bit has no effect
         lowPowerActive <= rate_r[`APMC_BIT_LOW_POWER] && running
            && activeCode >= `APMC_CODE_LP_LO && activeCode <= `APMC_CODE_LP_HI;
         altAddrSel <= i2cMode & addrSync_r[1];
      end
   end

   // standby never clears fifo; consumer only holds it
   assign fifoHold = !running;

   // 4-wire SPI never drives the data pin
   assign dataPinOut = serialOutBit;
   assign dataPinOutEn = serialOutEn & (i2cMode | spi3Wire);
   assign dataPinRx = pinSync_r[1];

   apmc_rate_tick u_tick (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(running),
      .rateCode(activeCode),
      .tick(sampleTick)
   );
endmodule // apmc_power_ctrl

// ### apmc_chk.sv
// port assertions for the power-mode controller
`timescale 1ns/10ps
`include "apmc_defs.vh"
module apmc_chk #(parameter TURNON_CYC = 20) (
   input wire clk,
   input wire sys_rst,
   input wire regWrite,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   input wire i2cMode,
   input wire spi3Wire,
   input wire serialOutEn,
   input wire dataPinOutEn,
   input wire dataPinIn,
   input wire dataPinRx,
   input wire altAddrSel,
   input wire measuring,
   input wire sleeping,
   input wire sampleTick,
   input wire dataValid,
   input wire fifoHold
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   wire pwrWr = regWrite && regAddr == `APMC_ADDR_PWR_CTL;
   AST_ON: assert property (pwrWr && regWdata[3] |-> ##[2:4] measuring)
      else $error("measure write ignored");
   AST_OFF: assert property (pwrWr && !regWdata[3] |-> ##[2:4] !measuring)
      else $error("standby not reached");
   AST_IDLE: assert property (fifoHold [*2] |-> !sampleTick && !dataValid && !measuring)
      else $error("activity in standby");
   AST_HOLD: assert property ($fell(measuring) |-> fifoHold)
      else $error("fifo not held");
   AST_TURNON: assert property ($rose(dataValid) |-> $past(measuring, TURNON_CYC))
      else $error("data valid too early");
   AST_DRV: assert property (dataPinOutEn == (serialOutEn && (i2cMode || spi3Wire)))
      else $error("data pin drive wrong");
   AST_RX: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |-> dataPinRx == $past(dataPinIn, 2))
      else $error("data pin input wrong");
   AST_ALT: assert property (!$past(i2cMode) |-> !altAddrSel)
      else $error("address select outside i2c");
   AST_SLP: assert property (sleeping |-> measuring && dataValid)
      else $error("sleep outside measurement");
endmodule // apmc_chk
bind apmc_power_ctrl apmc_chk #(.TURNON_CYC(TURNON_CYC)) chk_u (
   .clk(clk),
   .sys_rst(sys_rst),
   .regWrite(regWrite),
   .regAddr(regAddr),
   .regWdata(regWdata),
   .i2cMode(i2cMode),
   .spi3Wire(spi3Wire),
   .serialOutEn(serialOutEn),
   .dataPinOutEn(dataPinOutEn),
   .dataPinIn(dataPinIn),
   .dataPinRx(dataPinRx),
   .altAddrSel(altAddrSel),
   .measuring(measuring),
   .sleeping(sleeping),
   .sampleTick(sampleTick),
   .dataValid(dataValid),
   .fifoHold(fifoHold)
);

// ### apmc_host_model.sv
// host model driving the controller register port
`timescale 1ns/10ps
module apmc_host_model (
   input wire clk,
   input wire [7:0] regRdata,
   output logic regWrite,
   output logic regRead,
   output logic [7:0] regAddr,
   output logic [7:0] regWdata
);
   initial
      {regWrite, regRead, regAddr, regWdata} = '0;
   // one strobe per byte; address and data held across the taking edge
   task automatic wr(input logic [7:0] a, d);
      @(negedge clk);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      @(negedge clk);
      d = regRdata;
   endtask
endmodule // apmc_host_model

// ### test_accel_power_mode_control.sv
// self-checking bench for the power-mode controller
`timescale 1ns/10ps
module test_accel_power_mode_control;
   logic clk, sys_rst, inactive, i2cMode, spi3Wire, serialOutBit, serialOutEn;
   logic dataPinIn, addrSelPinIn, regWrite, regRead, dataPinOut, dataPinOutEn;
   logic dataPinRx, altAddrSel, measuring, sleeping, lowPowerActive;
   logic sampleTick, dataValid, fifoHold;
   logic [7:0] regAddr, regWdata, regRdata, inactThreshold, inactTime, rv;
   int miscompares, compares, n, k;
   apmc_power_ctrl #(.TURNON_CYC(20)) dut_u (
      .clk(clk),
      .sys_rst(sys_rst),
      .regWrite(regWrite),
      .regRead(regRead),
      .regAddr(regAddr),
      .regWdata(regWdata),
      .regRdata(regRdata),
      .inactive(inactive),
      .i2cMode(i2cMode),
      .spi3Wire(spi3Wire),
      .serialOutBit(serialOutBit),
      .serialOutEn(serialOutEn),
      .dataPinOut(dataPinOut),
      .dataPinOutEn(dataPinOutEn),
      .dataPinIn(dataPinIn),
      .addrSelPinIn(addrSelPinIn),
      .dataPinRx(dataPinRx),
      .altAddrSel(altAddrSel),
      .measuring(measuring),
      .sleeping(sleeping),
      .lowPowerActive(lowPowerActive),
      .sampleTick(sampleTick),
      .dataValid(dataValid),
      .fifoHold(fifoHold),
      .inactThreshold(inactThreshold),
      .inactTime(inactTime)
   );
   apmc_host_model host_u (
      .clk(clk),
      .regRdata(regRdata),
      .regWrite(regWrite),
      .regRead(regRead),
      .regAddr(regAddr),
      .regWdata(regWdata)
   );
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic bail;
      miscompares++;
      $display("MISMATCH %0t: timeout", $time);
      stop_test;
   endtask
   task automatic t_regs;
      logic [7:0] a [4] = '{8'h25, 8'h26, 8'h2C, 8'h2D};
      logic [7:0] r [4] = '{8'h00, 8'h00, 8'h0A, 8'h00};
      chk(8'(fifoHold), 8'h01);
      for (int i = 0; i < 4; i++)
      begin
         host_u.rd(a[i], rv);
         chk(rv, r[i]);
         host_u.wr(a[i], 8'h50 + i);
         host_u.rd(a[i], rv);
         chk(rv, 8'h50 + i);
      end
      chk(inactThreshold, 8'h50);
      chk(inactTime, 8'h51);
      host_u.rd(8'h30, rv);
      chk(rv, 8'h00);
      $display("registers done");
   endtask
   task automatic t_pins;
      for (int i = 0; i < 8; i++)
      begin
         {i2cMode, spi3Wire, serialOutEn} = 3'(i);
         {dataPinIn, addrSelPinIn, serialOutBit} = {i[1], i[1] ^ i[0], i[0]};
         repeat (4) @(negedge clk);
         chk(8'(dataPinOutEn), 8'(i[0] & (i[2] | i[1])));
         chk(8'(dataPinOut), 8'(i[0]));
         chk(8'(dataPinRx), 8'(i[1]));
         chk(8'(altAddrSel), 8'(i[2] & (i[1] ^ i[0])));
      end
      $display("pins done");
   endtask
   task automatic t_run;
      host_u.wr(8'h2C, 8'h1F);
      host_u.wr(8'h2D, 8'h08);
      while (dataValid !== 1'b1 && n < 90000)
      begin
         @(negedge clk);
         n++;
         k += sampleTick;
      end
      if (dataValid !== 1'b1)
         bail;
      // one 3200 Hz period (78125 cycles) plus the 20-cycle turn-on delay
      chk(8'(n >= 78145 && n <= 78160), 8'h01);
      chk(8'(k), 8'h01);
      chk(8'(fifoHold), 8'h00);
      chk(8'(lowPowerActive), 8'h00);
      host_u.wr(8'h2C, 8'h1C);
      repeat (3) @(negedge clk);
      chk(8'(lowPowerActive), 8'h01);
      $display("measure done");
   endtask
   task automatic t_sleep;
      host_u.wr(8'h25, 8'h10);
      host_u.wr(8'h26, 8'h05);
      chk(inactThreshold, 8'h10);
      chk(inactTime, 8'h05);
      inactive = 1'b1;
      // sleep-enable without link must not sleep
      host_u.wr(8'h2D, 8'h18);
      repeat (6) @(negedge clk);
      chk(8'(sleeping), 8'h00);
      host_u.wr(8'h2D, 8'h38);
      n = 0;
      while (sleeping !== 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      if (sleeping !== 1'b1)
         bail;
      chk(8'(lowPowerActive), 8'h00);
      inactive = 1'b0;
      repeat (6) @(negedge clk);
      chk(8'(sleeping), 8'h00);
      chk(8'(dataValid), 8'h00);
      host_u.wr(8'h2D, 8'h00);
      repeat (3) @(negedge clk);
      chk(8'(measuring), 8'h00);
      chk(8'(fifoHold), 8'h01);
      $display("sleep done");
   endtask
   initial
   begin
      sys_rst = 1'b1;
      {inactive, i2cMode, spi3Wire, serialOutBit, serialOutEn, dataPinIn, addrSelPinIn} = 7'h00;
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      t_regs;
      t_pins;
      t_run;
      t_sleep;
      stop_test;
   end
endmodule // test_accel_power_mode_control
